// file: csb_pkg.sv
// ==========================================================
// codec slot buffer shared definitions
package csb_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_LOC = 4;
  localparam int WORD_W = 16;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] LAST_SLOT = 4'hF;
  localparam logic [3:0] FIRST_SLOT = 4'h0;
  localparam logic [1:0] LOC_FIRST = 2'h0;
  localparam logic [1:0] LOC_STEP = 2'h1;
  localparam logic [3:0] CNT_STEP = 4'h1;

  // ==========================================================
  // register word indices, byte address is four times these
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX_SLOT_EN = 4'h1;
  localparam logic [3:0] REG_RX_SLOT_EN = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_TX_BUF0 = 4'h4;
  localparam logic [3:0] REG_RX_BUF0 = 4'h8;

  // ==========================================================
  // reset values and masks
  localparam logic [15:0] CTRL_WMASK = 16'h033F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SLOT_EN_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [31:0] BUS_ZERO = 32'h00000000;

  // ==========================================================
  // field layouts
  typedef struct packed {
    logic [5:0] unused_hi;
    logic [1:0] buffer_length_sel;
    logic [1:0] unused_mid;
    logic dma_sel;
    logic underflow_fill_mode;
    logic idle_output_mode;
    logic loopback_ctrl;
    logic fs_master;
    logic enable;
  } csb_ctrl_t;

  typedef struct packed {
    logic [3:0] unused_hi;
    logic [3:0] slot;
    logic [3:0] unused_mid;
    logic rx_overflow_flag;
    logic rx_full_flag;
    logic tx_underflow_flag;
    logic tx_empty_flag;
  } csb_status_t;

  // frame sync generator states
  typedef enum logic [2:0] {
    FR_OFF = 3'b001,
    FR_WAIT = 3'b010,
    FR_RUN = 3'b100
  } csb_frame_t;
endpackage : csb_pkg

// file: csb_codec_serial_if.sv
// Contract
// [RULE1] as sync master, pulse the frame sync pin whenever the generator resets
// [RULE2] as sync slave, reset the generator on each received frame sync pulse; pulses arriving mid-frame are ignored
// [RULE3] up to 16 slots per frame; stop buffering after the frame until next sync
// [RULE4] buffer counter steps once per slot enabled for transmit or receive
// [RULE5] counter low bits equal length setting: clear counter, swap shadows and buffers
// [RULE6] with dma selected, request a transfer whenever the irq flag sets
// [RULE7] software using dma sets buffer length to one word
// [RULE8] transmit empty flag sets when buffers move into transmit shadows
// [RULE9] any write to one of four transmit buffers clears transmit empty
// [RULE10] underflow sets at transfer for unrefilled buffers, clears on rewrite
// [RULE11] locations beyond buffer length never affect any status flag; their transmit buffer writes still clear transmit empty
// [RULE12] receive full shows new data, clears when all used buffers read
// [RULE13] overflow sets on unread overwrite, clears when that location is read
// [RULE14] 4-bit slot indicator equals frame sync generator counter
// [RULE15] idle mode clear: drive data out low in disabled transmit slots
// [RULE16] idle mode set: tri-state data out in disabled transmit slots
// [RULE17] loopback routes data out to data in, ignoring the input pin
// [RULE18] underflow with fill clear sends zeros for that location
// [RULE19] underflow with fill set resends last value written there
// [RULE20] buffers follow counter; four enabled slots map buffer n to slot n
// [RULE21] buffer length selects one to four words between interrupts
// [RULE22] enabled transmit slot loads current shadow to shifter, then counter steps
// [RULE23] enabled receive slot stores shifter in current shadow, then counter steps
// [RULE24] irq flag pulses each time buffer length is reached and shadows swap
// [RULE25] four 16-bit transmit and receive buffers, each with a shadow
`timescale 1ns/100ps
module csb_codec_serial_if
  import csb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bit_clk_pin,
  input wire logic frame_sync_pin_in,
  output logic frame_sync_pin_out,
  output logic frame_sync_pin_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic codec_if_irq_flag,
  output logic dma_req
);
  // ==========================================================
  // declarations
  csb_ctrl_t ctrl;
  csb_status_t status;
  csb_frame_t frame_state;
  logic [15:0] tx_slot_enable;
  logic [15:0] rx_slot_enable;
  logic [WORD_W-1:0] tx_buffer [NUM_LOC];
  logic [WORD_W-1:0] tx_shadow [NUM_LOC];
  logic [WORD_W-1:0] rx_buffer [NUM_LOC];
  logic [WORD_W-1:0] rx_shadow [NUM_LOC];
  logic [NUM_LOC-1:0] tx_written, unf_loc, rx_unread, rov_loc;
  logic [NUM_LOC-1:0] in_use, wr_tx, rd_rx;
  logic tx_empty_flag;
  logic [2:0] bclk_sync;
  logic [1:0] sdi_sync, fs_sync;
  logic rise_evt, fall_evt, sdi_sel;
  logic wr_acc, rd_acc;
  logic [15:0] rd_mux;
  logic [3:0] bit_cnt, slot_cnt, next_slot;
  logic fs_pending, frame_last, ready_for_frame, gen_reset, slot_start;
  logic [WORD_W-1:0] tx_shreg, rx_shreg, rx_word;
  logic tx_live;
  logic [1:0] buf_ptr;
  logic slot_end, cur_tx_en, cur_rx_en, advance, xfer;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================
  // pin synchronisers, stage 0 feeds only stage 1
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bclk_sync <= 3'h0;
      fs_sync <= 2'h0;
      sdi_sync <= 2'h0;
    end else begin
      bclk_sync <= {bclk_sync[1:0], bit_clk_pin};
      fs_sync <= {fs_sync[0], frame_sync_pin_in};
      sdi_sync <= {sdi_sync[0], serial_data_in};
    end
  end

  // bit clock edges from the settled stages
  assign rise_evt = bclk_sync[1] & ~bclk_sync[2];
  assign fall_evt = ~bclk_sync[1] & bclk_sync[2];
  // [RULE17] loopback input select
  assign sdi_sel = ctrl.loopback_ctrl ? tx_shreg[WORD_W-1] : sdi_sync[1];

  // ==========================================================
  // avalon slave: one wait cycle, then answer
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign rd_acc = avs_read & ~avs_waitrequest;

  // waitrequest drops for exactly the accepting cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_mux = WORD_ZERO;
    if (avs_address == REG_CTRL) begin
      rd_mux = ctrl;
    end else if (avs_address == REG_TX_SLOT_EN) begin
      rd_mux = tx_slot_enable;
    end else if (avs_address == REG_RX_SLOT_EN) begin
      rd_mux = rx_slot_enable;
    end else if (avs_address == REG_STATUS) begin
      rd_mux = status;
    end else if (avs_address[3:2] == REG_TX_BUF0[3:2]) begin
      rd_mux = tx_buffer[avs_address[1:0]];
    end else if (avs_address[3:2] == REG_RX_BUF0[3:2]) begin
      rd_mux = rx_buffer[avs_address[1:0]];
    end
  end

  // read data captured as waitrequest falls
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      avs_readdata <= BUS_ZERO;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {WORD_ZERO, rd_mux};
    end
  end

  // control and slot enable registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl <= csb_ctrl_t'(CTRL_RESET);
      tx_slot_enable <= SLOT_EN_RESET;
      rx_slot_enable <= SLOT_EN_RESET;
    end else if (wr_acc) begin
      if (avs_address == REG_CTRL) begin
        ctrl <= csb_ctrl_t'(merge16(ctrl, avs_writedata, avs_byteenable) & CTRL_WMASK);
      end
      if (avs_address == REG_TX_SLOT_EN) begin
        tx_slot_enable <= merge16(tx_slot_enable, avs_writedata, avs_byteenable);
      end
      if (avs_address == REG_RX_SLOT_EN) begin
        rx_slot_enable <= merge16(rx_slot_enable, avs_writedata, avs_byteenable);
      end
    end
  end

  // ==========================================================
  // per-location decode
  generate
    for (genvar i = 0; i < NUM_LOC; i++) begin : g_loc
      // [RULE21] length select picks locations in use
      assign in_use[i] = 2'(i) <= ctrl.buffer_length_sel;
      assign wr_tx[i] = wr_acc && (avs_address == REG_TX_BUF0 + 4'(i));
      assign rd_rx[i] = rd_acc && (avs_address == REG_RX_BUF0 + 4'(i));
    end
  endgenerate

  // [RULE11] underflow, full and overflow flags only see locations in use
  always_comb begin
    status = '0;
    status.tx_empty_flag = tx_empty_flag;
    status.tx_underflow_flag = |(unf_loc & in_use);
    status.rx_full_flag = |(rx_unread & in_use);
    status.rx_overflow_flag = |(rov_loc & in_use);
    // [RULE14] slot indicator from generator
    status.slot = slot_cnt;
  end

  // ==========================================================
  // frame sync generator
  assign frame_last = (bit_cnt == LAST_BIT) && (slot_cnt == LAST_SLOT);
  assign ready_for_frame = (frame_state == FR_WAIT) || ((frame_state == FR_RUN) && frame_last);
  // [RULE2] slave resets on a received pulse
  assign gen_reset = rise_evt && ctrl.enable && ready_for_frame && (ctrl.fs_master || fs_pending);
  assign slot_start = gen_reset || (rise_evt && (frame_state == FR_RUN) && (bit_cnt == LAST_BIT)
                                    && !frame_last);
  assign next_slot = gen_reset ? FIRST_SLOT : slot_cnt + CNT_STEP;

  // slave pulse seen while ready; extra pulses mid-frame are ignored
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fs_pending <= 1'b0;
    end else if (!ctrl.enable || ctrl.fs_master || gen_reset) begin
      fs_pending <= 1'b0;
    end else if (fall_evt && fs_sync[1] && ready_for_frame) begin
      fs_pending <= 1'b1;
    end
  end

  // [RULE3] one frame of 16 slots, then wait for sync
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      frame_state <= FR_OFF;
      bit_cnt <= FIRST_SLOT;
      slot_cnt <= FIRST_SLOT;
    end else if (!ctrl.enable) begin
      frame_state <= FR_OFF;
    end else if (gen_reset) begin
      frame_state <= FR_RUN;
      bit_cnt <= FIRST_SLOT;
      slot_cnt <= FIRST_SLOT;
    end else begin
      unique case (frame_state)
        FR_OFF: begin
          frame_state <= FR_WAIT;
        end
        FR_WAIT: begin
          frame_state <= FR_WAIT;
        end
        FR_RUN: begin
          if (rise_evt && frame_last) begin
            frame_state <= FR_WAIT;
          end else if (slot_start) begin
            bit_cnt <= FIRST_SLOT;
            slot_cnt <= next_slot;
          end else if (rise_evt) begin
            bit_cnt <= bit_cnt + CNT_STEP;
          end
        end
      endcase
    end
  end

  // [RULE1] master drives one bit period of sync per reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      frame_sync_pin_out <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
    end else begin
      frame_sync_pin_oe <= ctrl.enable && ctrl.fs_master;
      if (gen_reset && ctrl.fs_master) begin
        frame_sync_pin_out <= 1'b1;
      end else if (rise_evt || !ctrl.enable) begin
        frame_sync_pin_out <= 1'b0;
      end
    end
  end

  a_master_sync: assert property (gen_reset && ctrl.fs_master |=> frame_sync_pin_out) // [RULE1]
    else $error("master reset gave no sync pulse");
  a_gen_reset: assert property (gen_reset |=> slot_cnt == 4'h0 && bit_cnt == 4'h0) // [RULE2]
    else $error("generator did not reset to slot zero");
  a_slot_indicator: assert property (status.slot == slot_cnt) // [RULE14]
    else $error("slot indicator differs from counter");

  // ==========================================================
  // transmit shifter and pin drive
  assign cur_tx_en = tx_slot_enable[slot_cnt];
  assign cur_rx_en = rx_slot_enable[slot_cnt];

  // [RULE22] load current shadow at slot start
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_shreg <= WORD_ZERO;
      tx_live <= 1'b0;
    end else if (!ctrl.enable || (rise_evt && frame_last && !gen_reset)) begin
      tx_shreg <= WORD_ZERO;
      tx_live <= 1'b0;
    end else if (slot_start) begin
      // [RULE15] disabled slot shifts zeros
      tx_shreg <= tx_slot_enable[next_slot] ? tx_shadow[buf_ptr] : WORD_ZERO;
      tx_live <= tx_slot_enable[next_slot];
    end else if (rise_evt && (frame_state == FR_RUN)) begin
      tx_shreg <= {tx_shreg[WORD_W-2:0], 1'b0};
    end
  end

  assign serial_data_out = tx_shreg[WORD_W-1];

  // [RULE16] release the line in unused slots when shared
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      serial_data_out_oe <= 1'b0;
    end else begin
      serial_data_out_oe <= ctrl.enable && (tx_live || !ctrl.idle_output_mode);
    end
  end

  a_idle_low: assert property (serial_data_out_oe && !tx_live |-> !serial_data_out) // [RULE15]
    else $error("unused slot not driven low");
  a_idle_tristate: assert property (serial_data_out_oe |-> $past(tx_live || !ctrl.idle_output_mode)) // [RULE16]
    else $error("unused slot driven in shared mode");

  // ==========================================================
  // receive shifter
  assign rx_word = {rx_shreg[WORD_W-2:0], sdi_sel};
  assign slot_end = fall_evt && (frame_state == FR_RUN) && (bit_cnt == LAST_BIT) && ctrl.enable;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_shreg <= WORD_ZERO;
    end else if (fall_evt && (frame_state == FR_RUN)) begin
      rx_shreg <= rx_word;
    end
  end

  a_loopback: assert property (fall_evt && frame_state == FR_RUN && ctrl.loopback_ctrl // [RULE17]
    |=> rx_shreg[0] == $past(tx_shreg[WORD_W-1]))
    else $error("loopback bit not taken from data out");

  // ==========================================================
  // buffer control counter
  // [RULE4] any enabled slot steps the counter
  assign advance = slot_end && (cur_tx_en || cur_rx_en);
  // [RULE5] match with length setting swaps shadows
  assign xfer = advance && (buf_ptr == ctrl.buffer_length_sel);

  // [RULE20] counter, not frame, picks the location
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      buf_ptr <= LOC_FIRST;
    end else if (xfer) begin
      buf_ptr <= LOC_FIRST;
    end else if (advance) begin
      buf_ptr <= buf_ptr + LOC_STEP;
    end
  end

  // [RULE24] irq pulse per swap, mirrored as dma request
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      codec_if_irq_flag <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      codec_if_irq_flag <= xfer;
      // [RULE6] dma request follows the irq flag
      dma_req <= xfer && ctrl.dma_sel;
    end
  end

  a_ptr_step: assert property (advance && !xfer |=> buf_ptr == $past(buf_ptr) + 2'h1) // [RULE4]
    else $error("counter did not step by one");
  a_ptr_wrap: assert property (xfer |=> buf_ptr == 2'h0) // [RULE5]
    else $error("counter not cleared at length match");
  a_irq_pulse: assert property (xfer |=> codec_if_irq_flag ##1 !codec_if_irq_flag) // [RULE24]
    else $error("irq flag not a single pulse on swap");
  a_dma_req: assert property (codec_if_irq_flag |-> dma_req == $past(ctrl.dma_sel)) // [RULE6]
    else $error("dma request does not follow irq flag");

  // ==========================================================
  // transmit buffers, shadows and flags
  // [RULE25] four buffer words and four shadows
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        tx_buffer[i] <= WORD_ZERO;
        tx_shadow[i] <= WORD_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_LOC; i++) begin
        if (wr_tx[i]) begin
          tx_buffer[i] <= merge16(tx_buffer[i], avs_writedata, avs_byteenable);
        end
        // [RULE18] zeros on underflow, [RULE19] else last written value
        if (xfer && in_use[i]) begin
          tx_shadow[i] <= (tx_written[i] || ctrl.underflow_fill_mode) ? tx_buffer[i] : WORD_ZERO;
        end
      end
    end
  end

  // refill and underflow tracking, set beats clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_written <= '0;
      unf_loc <= '0;
    end else begin
      for (int i = 0; i < NUM_LOC; i++) begin
        if (wr_tx[i]) begin
          tx_written[i] <= 1'b1;
        end else if (xfer) begin
          tx_written[i] <= 1'b0;
        end
        // [RULE10] underflow set on swap, cleared by rewrite
        if (xfer && in_use[i] && !tx_written[i]) begin
          unf_loc[i] <= 1'b1;
        end else if (wr_tx[i]) begin
          unf_loc[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_empty_flag <= 1'b0;
    end else if (xfer) begin
      // [RULE8] empty on swap
      tx_empty_flag <= 1'b1;
    end else if (|wr_tx) begin
      // [RULE9] any buffer write clears empty
      tx_empty_flag <= 1'b0;
    end
  end

  a_empty_set: assert property (xfer |=> tx_empty_flag) // [RULE8]
    else $error("empty flag not set on swap");
  a_empty_clear: assert property (|wr_tx && !xfer |=> !tx_empty_flag) // [RULE9]
    else $error("empty flag not cleared by write");
  a_unf_flag: assert property (xfer && !tx_written[0] |=> status.tx_underflow_flag) // [RULE10]
    else $error("underflow flag not set");
  a_unf_zero: assert property (xfer && !tx_written[0] && !ctrl.underflow_fill_mode |=> ~|tx_shadow[0]) // [RULE18]
    else $error("underflow shadow not zero");
  a_unf_repeat: assert property (xfer && ctrl.underflow_fill_mode |=> tx_shadow[0] == $past(tx_buffer[0])) // [RULE19]
    else $error("underflow shadow not last written value");

  // ==========================================================
  // receive shadows, buffers and flags
  // [RULE23] store shifter in current shadow
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        rx_shadow[i] <= WORD_ZERO;
      end
    end else if (slot_end && cur_rx_en) begin
      rx_shadow[buf_ptr] <= rx_word;
    end
  end

  // swap forwards the word landing in this very cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        rx_buffer[i] <= WORD_ZERO;
      end
    end else if (xfer) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        if (in_use[i]) begin
          rx_buffer[i] <= (cur_rx_en && (buf_ptr == 2'(i))) ? rx_word : rx_shadow[i];
        end
      end
    end
  end

  // unread and overflow marks, swap beats a read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_unread <= '0;
      rov_loc <= '0;
    end else begin
      for (int i = 0; i < NUM_LOC; i++) begin
        // [RULE12] full until each used buffer is read
        if (xfer && in_use[i]) begin
          rx_unread[i] <= 1'b1;
        end else if (rd_rx[i]) begin
          rx_unread[i] <= 1'b0;
        end
        // [RULE13] overwrite of unread word flags overflow
        if (xfer && in_use[i] && rx_unread[i]) begin
          rov_loc[i] <= 1'b1;
        end else if (rd_rx[i]) begin
          rov_loc[i] <= 1'b0;
        end
      end
    end
  end

  a_rx_full: assert property (xfer |=> status.rx_full_flag) // [RULE12]
    else $error("full flag not set on swap");
  a_rx_overflow: assert property (xfer && rx_unread[0] |=> rov_loc[0]) // [RULE13]
    else $error("overflow not flagged on unread overwrite");
  a_unused_loc: assert property (ctrl.buffer_length_sel == 2'h0 && !unf_loc[0] // [RULE11]
    && !rov_loc[0] && !rx_unread[0] |-> status[3:1] == 3'h0)
    else $error("unused location reached a flag");

  c_swap: cover property (xfer ##1 codec_if_irq_flag);
  c_underflow: cover property (xfer && !tx_written[0]);
  c_overflow: cover property (xfer && rx_unread[0]);
  c_slave_frame: cover property (gen_reset && !ctrl.fs_master);
endmodule : csb_codec_serial_if

// file: csb_codec_model.sv
`timescale 1ns/100ps
// ==========================================
// codec partner: bit clock, frame sync and input data
module csb_codec_model (
  input wire logic run,
  input wire logic send_sync,
  output logic bit_clk,
  output logic sdi,
  output logic fs
);
  // clock stands still while run is low
  initial begin
    bit_clk = 1'b0;
    sdi = 1'b0;
    fs = 1'b0;
    forever begin
      #80;
      if (run) begin
        bit_clk = ~bit_clk;
      end
      // data flips each rise, so a wrongly used pin shows up
      // sync changes on the rise so the design sees it on the fall
      if (run && bit_clk) begin
        sdi = ~sdi;
        fs = send_sync;
      end
    end
  end
endmodule : csb_codec_model

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import csb_pkg::*;
  logic core_clk, nrst, avs_read, avs_write, run, fs_seen, send_sync, fs_in;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, lfsr_state;
  logic avs_waitrequest, bit_clk_pin, serial_data_in, fs_out, fs_oe, sdo, sdo_oe, irq, dma_req;
  logic [15:0] q, v1, v2, v3;
  int n_errors, total_checks;
  int n_irq, n0;

  csb_codec_model partner (.run(run), .send_sync(send_sync), .bit_clk(bit_clk_pin), .sdi(serial_data_in),
    .fs(fs_in));
  csb_codec_serial_if DUT (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bit_clk_pin(bit_clk_pin), .frame_sync_pin_in(fs_in), .frame_sync_pin_out(fs_out),
    .frame_sync_pin_oe(fs_oe), .serial_data_in(serial_data_in), .serial_data_out(sdo),
    .serial_data_out_oe(sdo_oe), .codec_if_irq_flag(irq), .dma_req(dma_req));

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [15:0] status_exp(input logic e, input logic u, input logic f, input logic o);
    return {12'h000, o, f, u, e};
  endfunction : status_exp

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0000, d};
    i = 0;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && i < 20) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 20) begin
      n_errors++;
      summarize;
    end
    r = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wait_irq;
    int i;
    i = 0;
    @(posedge core_clk);
    while (irq !== 1'b1 && i < 6000) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 6000) begin
      n_errors++;
      summarize;
    end
    check({15'h0000, dma_req}, 16'h0001);
  endtask : wait_irq

  // ==========================================
  // clock and sync pulse watch
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (fs_out === 1'b1) begin
      fs_seen <= 1'b1;
    end
    // irq pulses counted so a missing sync can be told from a slow one
    if (irq === 1'b1) begin
      n_irq <= n_irq + 1;
    end
  end

  // ==========================================
  // main sequence
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = BUS_ZERO;
    run = 1'b0;
    fs_seen = 1'b0;
    send_sync = 1'b0;
    n_irq = 0;
    n0 = 0;
    n_errors = 0;
    total_checks = 0;
    lfsr_state = 32'h0000F07F;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    run <= 1'b1;
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check(q, status_exp(0, 0, 0, 0));
    bus(1'b0, 4'hC, WORD_ZERO, q);
    check(q, WORD_ZERO);
    bus(1'b1, REG_CTRL, 16'hFFFE, q);
    bus(1'b0, REG_CTRL, WORD_ZERO, q);
    check(q, 16'h033E);
    $display("test registers done");
    lfsr_state = lfsr_next(lfsr_state);
    v1 = lfsr_state[15:0];
    bus(1'b1, REG_TX_BUF0, v1, q);
    bus(1'b1, REG_TX_SLOT_EN, 16'h0001, q);
    bus(1'b1, REG_RX_SLOT_EN, 16'h0001, q);
    // one word with dma, master, loopback
    bus(1'b1, REG_CTRL, 16'h0027, q);
    wait_irq;
    check({15'h0000, fs_seen & fs_oe}, 16'h0001);
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check(q & 16'h000F, status_exp(1, 0, 1, 0));
    bus(1'b0, REG_RX_BUF0, WORD_ZERO, q);
    check(q, WORD_ZERO);
    repeat (100) @(posedge core_clk);
    check({14'h0000, sdo_oe, sdo}, 16'h0002);
    lfsr_state = lfsr_next(lfsr_state);
    v2 = lfsr_state[15:0];
    bus(1'b1, REG_TX_BUF0, v2, q);
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check(q & 16'h000F, status_exp(0, 0, 0, 0));
    wait_irq;
    bus(1'b0, REG_RX_BUF0, WORD_ZERO, q);
    check(q, v1);
    $display("test transfer done");
    wait_irq;
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check(q & 16'h000F, status_exp(1, 1, 1, 0));
    wait_irq;
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check(q & 16'h000F, status_exp(1, 1, 1, 1));
    bus(1'b0, REG_RX_BUF0, WORD_ZERO, q);
    check(q, WORD_ZERO);
    lfsr_state = lfsr_next(lfsr_state);
    v3 = lfsr_state[15:0];
    bus(1'b1, REG_TX_BUF0, v3, q);
    bus(1'b1, REG_CTRL, 16'h0037, q);
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check(q & 16'h000F, status_exp(0, 0, 0, 0));
    repeat (3) wait_irq;
    bus(1'b0, REG_RX_BUF0, WORD_ZERO, q);
    check(q, v3);
    $display("test underflow done");
    // slave idles without sync, shared line released
    n0 = n_irq;
    bus(1'b1, REG_CTRL, 16'h003D, q);
    repeat (4200) @(posedge core_clk);
    check(16'(n_irq - n0), WORD_ZERO);
    check({13'h0000, fs_oe, sdo_oe, sdo}, WORD_ZERO);
    bus(1'b0, REG_STATUS, WORD_ZERO, q);
    check({12'h000, q[11:8]}, {12'h000, LAST_SLOT});
    send_sync <= 1'b1;
    repeat (20) @(posedge core_clk);
    send_sync <= 1'b0;
    wait_irq;
    bus(1'b0, REG_RX_BUF0, WORD_ZERO, q);
    check(q, v3);
    $display("test slave done");
    summarize;
  end
endmodule : testbench
